// ==== logic/mea_pkg.sv ====
// package: shared widths, encodings and capture record types for the sampler
package mea_pkg;
  localparam int ADDR_W = 64;
  localparam int LAT_W = 16;
  localparam int CNT_W = 32;
  localparam int BTB_DEPTH = 4;
  localparam logic [LAT_W-1:0] LAT_ZERO = 16'h0000;
  localparam logic [LAT_W-1:0] LAT_ONE = 16'h0001;
  localparam logic [CNT_W-1:0] CNT_ONE = 32'h00000001;
  localparam logic [ADDR_W-1:0] ADDR_ZERO = 64'h0000000000000000;

  // who serviced an instruction translation miss
  typedef enum logic {MEA_IT_WALKER, MEA_IT_SOFTWARE} mea_itsrc_t;
  // who serviced a data translation miss
  typedef enum logic [1:0] {MEA_DT_SECOND_LEVEL, MEA_DT_WALKER,
                            MEA_DT_SOFTWARE} mea_dtsrc_t;
  // misprediction reason of a branch
  typedef enum logic [1:0] {MEA_BR_NONE, MEA_BR_DIRECTION, MEA_BR_TARGET,
                            MEA_BR_OTHER} mea_brwhy_t;

  typedef struct packed {
    logic valid;
    logic [ADDR_W-1:0] iaddr;
    logic [LAT_W-1:0] latency;
  } mea_icap_t;

  typedef struct packed {
    logic valid;
    logic [ADDR_W-1:0] iaddr;
    mea_itsrc_t src;
  } mea_itcap_t;

  typedef struct packed {
    logic valid;
    logic [ADDR_W-1:0] iaddr;
    logic [ADDR_W-1:0] daddr;
    logic [LAT_W-1:0] latency;
  } mea_dcap_t;

  typedef struct packed {
    logic valid;
    logic [ADDR_W-1:0] iaddr;
    logic [ADDR_W-1:0] daddr;
    mea_dtsrc_t src;
  } mea_dtcap_t;

  typedef struct packed {
    logic [ADDR_W-1:0] baddr;
    logic [ADDR_W-1:0] taddr;
    logic mispredicted;
    mea_brwhy_t reason;
  } mea_brent_t;
endpackage

// ==== logic/mea_branch_trace.sv ====
// file: circular four-entry branch trace buffer
`timescale 1ns/100ps
module mea_branch_trace #(
  parameter int DEPTH = mea_pkg::BTB_DEPTH
) (
  input wire logic clock, // core clock
  input wire logic sys_rst, // synchronous reset, active high
  input wire logic br_valid, // one branch outcome this cycle
  input wire mea_pkg::mea_brent_t br_entry, // outcome to record
  input wire logic freeze, // capture suspended
  output mea_pkg::mea_brent_t entries [DEPTH], // stored entries, by slot
  output logic [$clog2(DEPTH)-1:0] wr_ptr // slot written next (oldest)
);
  import mea_pkg::*;

  localparam int PW = $clog2(DEPTH);
  localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);
  localparam logic [PW-1:0] PTR_ZERO = '0;

  mea_brent_t mem_reg [DEPTH];
  logic [PW-1:0] ptr_reg;
  logic [PW-1:0] ptr_next;
  logic wr_en;

  // =====================================================================
  // write pointer
  // pointer wraps so the newest outcome overwrites the oldest
  always_comb
  begin
    wr_en = br_valid && !freeze;
    ptr_next = ptr_reg;
    if (wr_en)
    begin
      ptr_next = (ptr_reg == PTR_LAST) ? PTR_ZERO : ptr_reg + 1'b1;
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      ptr_reg <= PTR_ZERO;
    end
    else
    begin
      ptr_reg <= ptr_next;
    end
  end

  // entry storage: address, target, mispredict and reason
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      for (int i = 0; i < DEPTH; i++)
      begin
        mem_reg[i] <= '0;
      end
    end
    else if (wr_en)
    begin
      mem_reg[ptr_reg] <= br_entry;
    end
  end

  assign entries = mem_reg;
  assign wr_ptr = ptr_reg;

  AST_BTB_WRAP: assert property (
    @(posedge clock) disable iff (sys_rst)
    (wr_en && ptr_reg == PTR_LAST) |=> ptr_reg == PTR_ZERO)
    else $error("branch trace pointer did not wrap");
  AST_BTB_STORE: assert property (
    @(posedge clock) disable iff (sys_rst)
    wr_en |=> mem_reg[$past(ptr_reg)] == $past(br_entry))
    else $error("branch entry not stored");
  AST_BTB_FREEZE: assert property (
    @(posedge clock) disable iff (sys_rst)
    freeze |=> $stable(ptr_reg))
    else $error("branch trace moved while frozen");
endmodule

// ==== logic/mea_sampler.sv ====
// file: top of the miss event address sampler
`timescale 1ns/100ps
// How it works
// - icache capture fires on demand fetch misses only, never prefetches
// - instruction cache capture stores fetch address and cycles in flight
// - instruction translation capture fires only on demand fetch misses
// - instruction translation capture stores address and servicing agent
// - data cache capture fires only on load misses, never stores
// - data cache capture stores both addresses and load latency
// - data translation capture takes any data miss and both its addresses
// - data translation capture stores servicing source among three agents
// - branch trace buffer keeps the four most recent branches
// - branch entry holds address, target, mispredict status and reason
// - data cache capture keeps overwriting with each new load miss
// - counter raises interrupt when it overflows after the chosen count
// - overflow freezes capture until software reads the capture registers
// - each capture register shows a readable valid indication
// - overflow interrupt supports event-based program counter sampling
module mea_sampler #(
  parameter int DEPTH = mea_pkg::BTB_DEPTH
) (
  input wire logic clock, // core clock, 125 MHz
  input wire logic sys_rst, // synchronous reset, active high
  input wire logic ic_miss, // first-level icache fetch miss retired
  input wire logic ic_prefetch, // that miss came from a prefetch
  input wire logic [mea_pkg::ADDR_W-1:0] ic_iaddr, // fetch address
  input wire logic [mea_pkg::LAT_W-1:0] ic_latency, // fetch cycles in flight
  input wire logic it_miss, // instruction translation miss serviced
  input wire logic it_prefetch, // that miss came from a prefetch
  input wire logic [mea_pkg::ADDR_W-1:0] it_iaddr, // fetch address
  input wire mea_pkg::mea_itsrc_t it_src, // servicing agent
  input wire logic dc_miss, // first-level data cache miss done
  input wire logic dc_is_load, // that access was a load
  input wire logic [mea_pkg::ADDR_W-1:0] dc_iaddr, // instruction address
  input wire logic [mea_pkg::ADDR_W-1:0] dc_daddr, // data address
  input wire logic [mea_pkg::LAT_W-1:0] dc_latency, // load cycles in flight
  input wire logic dt_miss, // data translation miss serviced
  input wire logic [mea_pkg::ADDR_W-1:0] dt_iaddr, // instruction address
  input wire logic [mea_pkg::ADDR_W-1:0] dt_daddr, // data address
  input wire mea_pkg::mea_dtsrc_t dt_src, // servicing agent
  input wire logic br_valid, // branch outcome this cycle
  input wire mea_pkg::mea_brent_t br_entry, // branch outcome
  input wire logic cnt_event, // counted event occurred
  input wire logic cnt_write, // software rewrites the counter
  input wire logic [mea_pkg::CNT_W-1:0] cnt_wdata, // preload value
  input wire logic cap_read, // software read the capture registers
  output mea_pkg::mea_icap_t ic_cap, // instruction cache capture
  output mea_pkg::mea_itcap_t it_cap, // instruction translation capture
  output mea_pkg::mea_dcap_t dc_cap, // data cache capture
  output mea_pkg::mea_dtcap_t dt_cap, // data translation capture
  output mea_pkg::mea_brent_t br_entries [DEPTH], // branch trace slots
  output logic [$clog2(DEPTH)-1:0] br_wr_ptr, // next slot, the oldest
  output logic [mea_pkg::CNT_W-1:0] cnt_value, // counter value
  output logic frozen, // capture suspended after overflow
  output logic ovf_irq // overflow interrupt, level until read
);
  import mea_pkg::*;

  // =====================================================================
  // state
  mea_icap_t ic_reg, ic_next;
  mea_itcap_t it_reg, it_next;
  mea_dcap_t dc_reg, dc_next;
  mea_dtcap_t dt_reg, dt_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic frz_reg, frz_next;
  logic irq_reg, irq_next;
  logic ovf;
  logic ic_take, it_take, dc_take, dt_take;

  // =====================================================================
  // qualification of capture triggers
  always_comb
  begin
    ic_take = ic_miss && !ic_prefetch && !frz_reg;
    it_take = it_miss && !it_prefetch && !frz_reg;
    dc_take = dc_miss && dc_is_load && !frz_reg;
    dt_take = dt_miss && !frz_reg;
  end

  // capture registers; a later miss simply overwrites the earlier one
  always_comb
  begin
    ic_next = ic_reg;
    it_next = it_reg;
    dc_next = dc_reg;
    dt_next = dt_reg;
    if (ic_take)
    begin
      ic_next = '{valid: 1'b1, iaddr: ic_iaddr,
                  latency: ic_latency};
    end
    if (it_take)
    begin
      it_next = '{valid: 1'b1, iaddr: it_iaddr, src: it_src};
    end
    if (dc_take)
    begin
      dc_next = '{valid: 1'b1, iaddr: dc_iaddr, daddr: dc_daddr,
                  latency: dc_latency};
    end
    if (dt_take)
    begin
      dt_next = '{valid: 1'b1, iaddr: dt_iaddr, daddr: dt_daddr,
                  src: dt_src};
    end
  end

  // =====================================================================
  // event counter, freeze and interrupt
  // a rewrite while an event arrives takes the rewrite: software owns it
  always_comb
  begin
    ovf = 1'b0;
    cnt_next = cnt_reg;
    if (cnt_write)
    begin
      cnt_next = cnt_wdata;
    end
    else if (cnt_event && !frz_reg)
    begin
      cnt_next = cnt_reg + CNT_ONE;
      ovf = (cnt_reg == '1);
    end
    // overflow sets and wins over a read in the same cycle
    frz_next = ovf ? 1'b1 : (cap_read ? 1'b0 : frz_reg);
    irq_next = ovf ? 1'b1 : (cap_read ? 1'b0 : irq_reg);
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      ic_reg <= '0;
      it_reg <= '0;
      dc_reg <= '0;
      dt_reg <= '0;
      cnt_reg <= '0;
      frz_reg <= 1'b0;
      irq_reg <= 1'b0;
    end
    else
    begin
      ic_reg <= ic_next;
      it_reg <= it_next;
      dc_reg <= dc_next;
      dt_reg <= dt_next;
      cnt_reg <= cnt_next;
      frz_reg <= frz_next;
      irq_reg <= irq_next;
    end
  end

  // =====================================================================
  // branch trace, stalled by the same freeze
  mea_branch_trace #(.DEPTH(DEPTH)) u_btb (
    .clock(clock),
    .sys_rst(sys_rst),
    .br_valid(br_valid),
    .br_entry(br_entry),
    .freeze(frz_reg),
    .entries(br_entries),
    .wr_ptr(br_wr_ptr)
  );

  assign ic_cap = ic_reg; // valid bit readable
  assign it_cap = it_reg;
  assign dc_cap = dc_reg;
  assign dt_cap = dt_reg;
  assign cnt_value = cnt_reg;
  assign frozen = frz_reg;
  assign ovf_irq = irq_reg;

  // =====================================================================
  // checks; each capture is checked for value and for staying put otherwise, the data cache one only on store misses
  AST_IC_PREFETCH: assert property (
    @(posedge clock) disable iff (sys_rst)
    (ic_prefetch || !ic_miss) |=> $stable(ic_reg))
    else $error("icache capture changed without demand miss");
  AST_IC_DATA: assert property (
    @(posedge clock) disable iff (sys_rst)
    (ic_miss && !ic_prefetch && !frz_reg) |=>
      ic_reg.valid && ic_reg.iaddr == $past(ic_iaddr)
      && ic_reg.latency == $past(ic_latency))
    else $error("icache capture wrong");
  AST_IT_PREFETCH: assert property (
    @(posedge clock) disable iff (sys_rst)
    (it_prefetch || !it_miss) |=> $stable(it_reg))
    else $error("instruction translation capture changed without miss");
  AST_IT_DATA: assert property (
    @(posedge clock) disable iff (sys_rst)
    (it_miss && !it_prefetch && !frz_reg) |=>
      it_reg.valid && it_reg.iaddr == $past(it_iaddr)
      && it_reg.src == $past(it_src))
    else $error("instruction translation capture wrong");
  AST_DC_STORE: assert property (
    @(posedge clock) disable iff (sys_rst)
    (dc_miss && !dc_is_load) |=> $stable(dc_reg))
    else $error("store miss altered data cache capture");
  AST_DC_DATA: assert property (
    @(posedge clock) disable iff (sys_rst)
    (dc_miss && dc_is_load && !frz_reg) |=>
      dc_reg.valid && dc_reg.daddr == $past(dc_daddr)
      && dc_reg.iaddr == $past(dc_iaddr)
      && dc_reg.latency == $past(dc_latency))
    else $error("dcache capture wrong");
  AST_DT_IDLE: assert property (
    @(posedge clock) disable iff (sys_rst)
    (!dt_miss || frz_reg) |=> $stable(dt_reg))
    else $error("data translation capture changed without miss");
  AST_DT_DATA: assert property (
    @(posedge clock) disable iff (sys_rst)
    (dt_miss && !frz_reg) |=> dt_reg.valid && dt_reg.src == $past(dt_src)
      && dt_reg.iaddr == $past(dt_iaddr)
      && dt_reg.daddr == $past(dt_daddr))
    else $error("data translation capture wrong");
  AST_OVF_IRQ: assert property (
    @(posedge clock) disable iff (sys_rst)
    (cnt_event && !cnt_write && !frz_reg && cnt_reg == '1) |=>
      ovf_irq && frozen && cnt_value == '0)
    else $error("overflow did not raise interrupt");
  AST_FREEZE_HOLD: assert property (
    @(posedge clock) disable iff (sys_rst)
    (frz_reg && !cap_read) |=> frz_reg && $stable(dc_reg)
      && $stable(ic_reg) && $stable(it_reg) && $stable(dt_reg))
    else $error("capture changed while frozen");
  // a frozen counter must not creep, or the next interval starts short
  AST_CNT_FROZEN: assert property (
    @(posedge clock) disable iff (sys_rst)
    (frz_reg && !cnt_write) |=> $stable(cnt_reg))
    else $error("counter moved while frozen");
  AST_READ_THAW: assert property (
    @(posedge clock) disable iff (sys_rst)
    (cap_read && !ovf) |=> !frozen && !ovf_irq)
    else $error("read did not resume capture");
endmodule

// ==== tb/mea_sw_model.sv ====
// file: monitoring software model that services the overflow interrupt
`timescale 1ns/100ps
module mea_sw_model #(
  parameter int DELAY = 3, // cycles the handler takes before reading
  parameter logic [31:0] RELOAD = 32'hfffffffe // preload of each interval
) (
  input wire logic clock, // core clock
  input wire logic arm, // bench asks for a first preload
  input wire logic ovf_irq, // overflow interrupt from the sampler
  output logic cap_read, // capture registers read
  output logic cnt_write, // counter rewrite strobe
  output logic [31:0] cnt_wdata // preload value
);
  int wait_cnt = 0;
  initial
  begin
    cap_read = 1'b0;
    cnt_write = 1'b0;
    cnt_wdata = 32'h0;
  end
  // read captures first, then rewrite the counter
  // data is scrambled outside a write so a stale value cannot pass
  always @(posedge clock)
  begin
    cap_read <= 1'b0;
    cnt_write <= arm | cap_read;
    cnt_wdata <= (arm | cap_read) ? RELOAD : ~cnt_wdata;
    if (ovf_irq && !cap_read)
      wait_cnt <= wait_cnt + 1;
    if (wait_cnt == DELAY)
    begin
      cap_read <= 1'b1;
      wait_cnt <= 0;
    end
  end
endmodule

// ==== tb/miss_event_address_sampler_tb_top.sv ====
// file: self-checking bench for the miss event address sampler
`timescale 1ns/100ps
module miss_event_address_sampler_tb_top;
  import mea_pkg::*;
  localparam logic [CNT_W-1:0] RELOAD = 32'hfffffffe;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic ic_miss, ic_prefetch, it_miss, it_prefetch, dc_miss, dc_is_load;
  logic dt_miss, br_valid, cnt_event, arm, cap_read, cnt_write;
  logic frozen, ovf_irq;
  logic [ADDR_W-1:0] ic_iaddr, it_iaddr, dc_iaddr, dc_daddr, dt_iaddr;
  logic [ADDR_W-1:0] dt_daddr;
  logic [LAT_W-1:0] ic_latency, dc_latency;
  logic [CNT_W-1:0] cnt_wdata, cnt_value;
  logic [$clog2(BTB_DEPTH)-1:0] br_wr_ptr;
  mea_itsrc_t it_src;
  mea_dtsrc_t dt_src;
  mea_brent_t br_entry;
  mea_brent_t br_entries [BTB_DEPTH];
  mea_icap_t ic_cap;
  mea_itcap_t it_cap;
  mea_dcap_t dc_cap;
  mea_dtcap_t dt_cap;
  int err_total = 0;
  int cmp_count = 0;

  always #4 clock = ~clock;

  mea_sampler u_dut (.clock, .sys_rst, .ic_miss, .ic_prefetch, .ic_iaddr,
    .ic_latency, .it_miss, .it_prefetch, .it_iaddr, .it_src, .dc_miss,
    .dc_is_load, .dc_iaddr, .dc_daddr, .dc_latency, .dt_miss, .dt_iaddr,
    .dt_daddr, .dt_src, .br_valid, .br_entry, .cnt_event, .cnt_write,
    .cnt_wdata, .cap_read, .ic_cap, .it_cap, .dc_cap, .dt_cap, .br_entries,
    .br_wr_ptr, .cnt_value, .frozen, .ovf_irq);

  mea_sw_model #(.DELAY(3), .RELOAD(RELOAD)) u_sw (.clock, .arm, .ovf_irq,
    .cap_read, .cnt_write, .cnt_wdata);

  // ==========================================================
  // common tasks
  task automatic stop_test();
  begin
    if (err_total == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  end
  endtask

  task automatic chk(input logic ok, input string msg);
  begin
    cmp_count++;
    if (ok !== 1'b1)
    begin
      err_total++;
      $display("CHECK FAILED %0t %s", $time, msg);
    end
  end
  endtask

  // one-cycle load or store miss, then an idle cycle so that a following
  // call never lowers and raises the strobe in one time step
  task automatic dc_pulse(input logic ld, input logic [ADDR_W-1:0] a);
  begin
    dc_miss = 1'b1;
    dc_is_load = ld;
    dc_iaddr = a;
    dc_daddr = ~a;
    dc_latency = a[LAT_W-1:0];
    @(negedge clock);
    dc_miss = 1'b0;
    @(negedge clock);
  end
  endtask

  // ==========================================================
  // scenarios
  // a demand miss lands, the prefetch right behind it is dropped
  task automatic t_fetch();
  begin
    ic_iaddr = 64'h1000;
    ic_latency = 16'h0007;
    ic_miss = 1'b1;
    it_iaddr = 64'h2000;
    it_src = MEA_IT_SOFTWARE;
    it_miss = 1'b1;
    @(negedge clock);
    {ic_iaddr, it_iaddr, ic_prefetch, it_prefetch} = {64'h3, 64'h4, 2'b11};
    @(negedge clock);
    {ic_miss, ic_prefetch, it_prefetch} = 3'b000;
    it_src = MEA_IT_WALKER;
    chk(ic_cap === {1'b1, 64'h1000, 16'h0007}, "icache");
    chk(it_cap === {1'b1, 64'h2000, MEA_IT_SOFTWARE}, "it");
    @(negedge clock);
    it_miss = 1'b0;
    chk(it_cap === {1'b1, 64'h4, MEA_IT_WALKER}, "it walk");
  end
  endtask

  // stores never capture, successive loads two cycles apart keep overwriting
  task automatic t_data();
    mea_dtcap_t exp_dt;
  begin
    dc_pulse(1'b0, 64'h50);
    chk(dc_cap.valid === 1'b0, "store captured");
    dc_pulse(1'b1, 64'h60);
    chk(dc_cap.iaddr === 64'h60, "dc first");
    dc_pulse(1'b1, 64'h70);
    chk(dc_cap === {1'b1, 64'h70, ~64'h70, 16'h0070}, "dc");
    // strobe stays up across the loop: one miss a cycle, each overwrites
    dt_miss = 1'b1;
    for (int i = 0; i < 3; i++)
    begin
      exp_dt = '{1'b1, 64'(i + 9), 64'(i + 5), mea_dtsrc_t'(i)};
      dt_iaddr = exp_dt.iaddr;
      dt_daddr = exp_dt.daddr;
      dt_src = exp_dt.src;
      @(negedge clock);
      chk(dt_cap === exp_dt, "dt");
    end
    dt_miss = 1'b0;
  end
  endtask

  // five branches into four slots: the first is overwritten
  task automatic t_branch();
    int k;
    mea_brent_t exp_br;
  begin
    br_valid = 1'b1;
    for (int i = 0; i < 5; i++)
    begin
      br_entry = {64'h100 + 64'(i), 64'h200 + 64'(i), i[0],
                  mea_brwhy_t'(i[1:0])};
      @(negedge clock);
    end
    br_valid = 1'b0;
    chk(br_wr_ptr === 2'h1, "branch pointer");
    // slot 0 now holds the fifth branch, slots 1 to 3 the second to fourth
    for (int i = 0; i < 4; i++)
    begin
      k = (i == 0) ? 4 : i;
      exp_br = {64'h100 + 64'(k), 64'h200 + 64'(k), k[0],
                mea_brwhy_t'(k[1:0])};
      chk(br_entries[i] === exp_br, "branch slot");
    end
  end
  endtask

  // overflow freezes capture until the handler reads and reloads
  task automatic t_overflow();
  begin
    arm = 1'b1;
    @(negedge clock);
    arm = 1'b0;
    @(negedge clock);
    chk(cnt_value === RELOAD, "preload");
    cnt_event = 1'b1;
    repeat (2) @(negedge clock);
    chk(frozen === 1'b1 && ovf_irq === 1'b1, "overflow");
    chk(cnt_value === 32'h0, "wrap");
    dc_pulse(1'b1, 64'h80);
    cnt_event = 1'b0;
    chk(dc_cap.iaddr === 64'h70, "frozen");
    chk(cnt_value === 32'h0, "count held");
    for (int n = 0; n < 20 && frozen !== 1'b0; n++)
      @(negedge clock);
    chk(frozen === 1'b0 && ovf_irq === 1'b0, "release");
    @(negedge clock);
    chk(cnt_value === RELOAD, "reload");
    dc_pulse(1'b1, 64'h90);
    chk(dc_cap.iaddr === 64'h90, "resume");
    chk(dc_cap.valid === 1'b1, "resume valid");
  end
  endtask

  // ==========================================================
  // main sequence and watchdog
  initial
  begin
    {ic_miss, ic_prefetch, it_miss, it_prefetch, dc_miss, dc_is_load} = 6'h0;
    {dt_miss, br_valid, cnt_event, arm} = 4'h0;
    {ic_iaddr, it_iaddr, dc_iaddr, dc_daddr, dt_iaddr, dt_daddr} = '0;
    {ic_latency, dc_latency, br_entry} = '0;
    it_src = MEA_IT_WALKER;
    dt_src = MEA_DT_SECOND_LEVEL;
    repeat (20) @(negedge clock);
    sys_rst = 1'b0;
    @(negedge clock);
    t_fetch();
    t_data();
    t_branch();
    t_overflow();
    stop_test();
  end

  // the whole run needs about fifty cycles
  initial
  begin
    repeat (2000) @(posedge clock);
    err_total++;
    stop_test();
  end
endmodule
